/* File: kbd_adapter.sv */
// Keyboard adapter: key latch, pending status, level 3 request, checks
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module kbd_adapter
  import kbd_adapter_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [7:0]  kbd_data,
  input  wire logic        kbd_parity,
  input  wire logic        kbd_strobe_n,
  input  wire logic [7:0]  bus_out,
  input  wire logic        bus_out_parity,
  input  wire logic        bus_out_valid,
  input  wire logic [7:0]  dev_addr,
  input  wire logic        dev_addr_parity,
  input  wire logic        dev_select,
  input  wire logic        proc_busy,
  output logic      [7:0]  bus_in,
  output logic             bus_in_parity,
  output logic             bus_in_oe,
  output logic             key_pending,
  output logic             level3_req,
  output logic             process_check,
  output logic             in_process_lamp,
  output logic             cycle_steal_en,
  output logic             display_blank,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  kbd_state_e        state_q;
  kbd_state_e        state_d;
  logic              strobe_prev_q;
  logic              strobe_fall;
  logic              halted;
  logic              take;
  logic              err_kbd;
  logic              err_out;
  logic              err_addr;
  logic              perr;
  logic [8:0]        latch_q;
  logic [8:0]        sel_q;
  logic              load_sel_q;
  logic              irq_en_q;
  logic              addr_ph;
  logic              wr_q;
  logic [ADDR_W-1:0] waddr_q;
  logic              wr_ctrl;
  logic              wr_ack;
  logic              wr_clr;
  logic              wr_en;
  logic              ack_irq;
  logic              ack_pend;
  logic [31:0]       rd_d;
  logic [EVT_N-1:0]  evt_set;
  logic [EVT_N-1:0]  evt_stat;
  logic [EVT_N-1:0]  evt_en;
  logic              kbd_hit;

  // ----------------------------------------------------------------
  // Strobe detect and parity checks
  // ----------------------------------------------------------------
  assign strobe_fall = strobe_prev_q && !kbd_strobe_n;
  assign halted      = state_q == ST_HALT;
  assign take        = strobe_fall && !halted && !perr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_prev_q <= 1'b1;
    end else if (clk_en) begin
      strobe_prev_q <= kbd_strobe_n;
    end
  end

  parity_check #(
    .W   (8),
    .ODD (1'b1)
  ) u_kbd_par (
    .data  (kbd_data),
    .par   (kbd_parity),
    .check (strobe_fall),
    .err   (err_kbd)
  );

  parity_check #(
    .W   (8),
    .ODD (1'b1)
  ) u_out_par (
    .data  (bus_out),
    .par   (bus_out_parity),
    .check (bus_out_valid),
    .err   (err_out)
  );

  parity_check #(
    .W   (8),
    .ODD (1'b0)
  ) u_addr_par (
    .data  (dev_addr),
    .par   (dev_addr_parity),
    .check (dev_select),
    .err   (err_addr)
  );

  // Checked even once halted; the halt is already sticky
  assign perr = err_kbd || err_out || err_addr;

  // ----------------------------------------------------------------
  // Pending status and halt state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (perr) begin
          state_d = ST_HALT;
        end else if (take) begin
          state_d = ST_PEND;
        end
      end
      ST_PEND: begin
        if (perr) begin
          state_d = ST_HALT;
        end else if (!take && ack_pend) begin
          state_d = ST_IDLE;
        end
      end
      ST_HALT: begin
        state_d = ST_HALT;
      end
      default: begin
        state_d = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign key_pending   = state_q[1];
  assign process_check = state_q[2];

  // ----------------------------------------------------------------
  // Data latch and data select register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q    <= DATA_RST;
      load_sel_q <= 1'b0;
    end else if (clk_en) begin
      load_sel_q <= take;
      if (take) begin
        latch_q <= {kbd_parity, kbd_data};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= DATA_RST;
    end else if (clk_en && load_sel_q) begin
      sel_q <= latch_q;
    end
  end

  // Driven only for our address; once halted the bus drops at the next edge
  assign kbd_hit = dev_select && dev_addr == KBD_DEV_ADDR && !halted;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_in        <= 8'h00;
      bus_in_parity <= 1'b0;
      bus_in_oe     <= 1'b0;
    end else if (clk_en) begin
      bus_in_oe     <= kbd_hit;
      bus_in        <= kbd_hit ? sel_q[7:0] : 8'h00;
      bus_in_parity <= kbd_hit ? sel_q[8] : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Level 3 interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level3_req <= 1'b0;
    end else if (clk_en) begin
      if (take && irq_en_q) begin
        level3_req <= 1'b1;
      end else if (ack_irq) begin
        level3_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor busy indicators
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_process_lamp <= 1'b0;
      cycle_steal_en  <= 1'b1;
      display_blank   <= 1'b0;
    end else if (clk_en) begin
      in_process_lamp <= proc_busy;
      cycle_steal_en  <= !proc_busy;
      display_blank   <= proc_busy;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign addr_ph  = hsel && hready && htrans[1];
  assign wr_ctrl  = wr_q && waddr_q == OFF_CTRL;
  assign wr_ack   = wr_q && waddr_q == OFF_ACK;
  assign wr_clr   = wr_q && waddr_q == OFF_EVT_CLR;
  assign wr_en    = wr_q && waddr_q == OFF_EVT_EN;
  assign ack_irq  = wr_ack && hwdata[ACK_IRQ];
  assign ack_pend = wr_ack && hwdata[ACK_PEND];

  // Zero wait states: read data is fetched during the address phase
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[ADDR_W-1:0])
      OFF_CTRL: begin
        rd_d[CTRL_IRQ_EN] = irq_en_q;
      end
      OFF_STATUS: begin
        rd_d[STAT_PEND]  = key_pending;
        rd_d[STAT_IRQ]   = level3_req;
        rd_d[STAT_CHECK] = process_check;
        rd_d[STAT_BUSY]  = in_process_lamp;
      end
      OFF_DATA: begin
        rd_d[8:0] = latch_q;
      end
      OFF_EVT_STAT: begin
        rd_d[EVT_N-1:0] = evt_stat;
      end
      OFF_EVT_EN: begin
        rd_d[EVT_N-1:0] = evt_en;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      hrdata  <= RDATA_RST;
    end else if (clk_en) begin
      wr_q <= addr_ph && hwrite;
      if (addr_ph) begin
        waddr_q <= haddr[ADDR_W-1:0];
        hrdata  <= hwrite ? RDATA_RST : rd_d;
      end
    end
  end

  // Single slave with no wait states and no error answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= CTRL_RST;
    end else if (clk_en && wr_ctrl) begin
      irq_en_q <= hwdata[CTRL_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    evt_set               = '0;
    evt_set[EVT_STROBE]   = take;
    evt_set[EVT_OUT_PAR]  = err_out;
    evt_set[EVT_KBD_PAR]  = err_kbd;
    evt_set[EVT_ADDR_PAR] = err_addr;
  end

  event_irq #(
    .N (EVT_N)
  ) u_evt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .set      (evt_set),
    .clr      (wr_clr ? hwdata[EVT_N-1:0] : '0),
    .en_we    (wr_en),
    .en_wdata (hwdata[EVT_N-1:0]),
    .status_q (evt_stat),
    .enable_q (evt_en),
    .irq_q    (irq)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_strobe_sets_pend: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && take |=> key_pending)
    else $error("strobe did not raise pending");

  a_latch_capture: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && take |=> latch_q == $past({kbd_parity, kbd_data}))
    else $error("latch missed keyboard code");

  a_sel_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && take ##1 clk_en |=> sel_q == $past(latch_q))
    else $error("select register not loaded");

  a_bus_in_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en |=> bus_in_oe == $past(kbd_hit)
      && (bus_in_oe || bus_in == 8'h00))
    else $error("bus in driven without select");

  a_irq_enabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && take |=> level3_req == ($past(irq_en_q)
      || ($past(level3_req) && !$past(ack_irq))))
    else $error("level 3 request wrong after strobe");

  a_irq_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    level3_req && !(clk_en && ack_irq) |=> level3_req)
    else $error("request dropped without reset");

  a_perr_halts: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && perr |=> process_check && !key_pending)
    else $error("parity error without process check");

  a_halt_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    process_check |=> process_check && !bus_in_oe)
    else $error("process check released");

  a_busy_lamps: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en |=> in_process_lamp == $past(proc_busy)
      && cycle_steal_en == !in_process_lamp
      && display_blank == in_process_lamp)
    else $error("busy indicators disagree");

  a_overwrite_keeps: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && key_pending && take |=> key_pending
      && latch_q == $past({kbd_parity, kbd_data}))
    else $error("overwrite lost pending");

endmodule

/* File: kbd_adapter_pkg.sv */
// Constants, register map and state encoding for the keyboard adapter
package kbd_adapter_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, low address bits)
  // ----------------------------------------------------------------
  localparam int unsigned     ADDR_W       = 8;
  localparam logic [7:0]      OFF_CTRL     = 8'h00;
  localparam logic [7:0]      OFF_STATUS   = 8'h04;
  localparam logic [7:0]      OFF_DATA     = 8'h08;
  localparam logic [7:0]      OFF_ACK      = 8'h0c;
  localparam logic [7:0]      OFF_EVT_STAT = 8'h10;
  localparam logic [7:0]      OFF_EVT_CLR  = 8'h14;
  localparam logic [7:0]      OFF_EVT_EN   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned     CTRL_IRQ_EN  = 0;
  localparam int unsigned     ACK_IRQ      = 0;
  localparam int unsigned     ACK_PEND     = 1;
  localparam int unsigned     STAT_PEND    = 0;
  localparam int unsigned     STAT_IRQ     = 1;
  localparam int unsigned     STAT_CHECK   = 2;
  localparam int unsigned     STAT_BUSY    = 3;
  localparam int unsigned     EVT_N        = 4;
  localparam int unsigned     EVT_STROBE   = 0;
  localparam int unsigned     EVT_OUT_PAR  = 1;
  localparam int unsigned     EVT_KBD_PAR  = 2;
  localparam int unsigned     EVT_ADDR_PAR = 3;

  // ----------------------------------------------------------------
  // Device address and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      KBD_DEV_ADDR = 8'h04;
  localparam logic            CTRL_RST     = 1'b0;
  localparam logic [3:0]      EVT_EN_RST   = 4'h0;
  localparam logic [8:0]      DATA_RST     = 9'h000;
  localparam logic [31:0]     RDATA_RST    = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PEND = 3'b010,
    ST_HALT = 3'b100
  } kbd_state_e;

endpackage

/* File: parity_check.sv */
// Parity checker for one group of lines with its check bit
`timescale 1ns/1ps
module parity_check #(
  parameter int unsigned W   = 8,
  parameter bit          ODD = 1'b1
) (
  input  wire logic [W-1:0] data,
  input  wire logic         par,
  input  wire logic         check,
  output logic              err
);
  logic ones_odd;

  // Odd sense: data plus check bit must hold an odd count of ones
  assign ones_odd = ^{data, par};
  assign err      = check && (ODD ? !ones_odd : ones_odd);
endmodule

/* File: event_irq.sv */
// Sticky event status, clear and enable with one level interrupt
`timescale 1ns/1ps
module event_irq #(
  parameter int unsigned N = 4
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  input  wire logic         en_we,
  input  wire logic [N-1:0] en_wdata,
  output logic      [N-1:0] status_q,
  output logic      [N-1:0] enable_q,
  output logic              irq_q
);
  logic [N-1:0] status_d;
  logic [N-1:0] enable_d;

  // Set wins over a clear in the same cycle so no event is lost
  assign status_d = (status_q & ~clr) | set;
  assign enable_d = en_we ? en_wdata : enable_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
      enable_q <= '0;
      irq_q    <= 1'b0;
    end else if (clk_en) begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q    <= |(status_d & enable_d);
    end
  end
endmodule

/* File: kbd_model.sv */
// Keyboard board model: code, odd parity and strobe toward the adapter
`timescale 1ns/1ps
module kbd_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       send,
  input  wire logic [7:0] code,
  input  wire logic       bad_par,
  output logic      [7:0] kbd_data,
  output logic            kbd_parity,
  output logic            kbd_strobe_n,
  output logic            done
);
  logic [2:0] cnt_q;

  // ----------------------------------------------------------------
  // Key press, hold and release
  // ----------------------------------------------------------------
  assign done = (cnt_q == 3'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q        <= 3'h0;
      kbd_strobe_n <= 1'b1;
      kbd_data     <= 8'h00;
      kbd_parity   <= 1'b0;
    end else if (send && done) begin
      kbd_data     <= code;
      kbd_parity   <= ~(^code) ^ bad_par;
      kbd_strobe_n <= 1'b0;
      cnt_q        <= 3'h5;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h4) begin
        kbd_strobe_n <= 1'b1;
      end
      // Released key: stale code must not look valid
      if (cnt_q == 3'h2) begin
        kbd_data   <= ~kbd_data;
        kbd_parity <= ~kbd_parity;
      end
    end
  end
endmodule

/* File: tb.sv */
// Testbench for the keyboard adapter
`timescale 1ns/1ps
module tb
  import kbd_adapter_pkg::*;
;
  typedef struct packed {
    logic [7:0]  code;
    logic [31:0] data;
  } row_s;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  kbd_data, bus_out, dev_addr, bus_in, code;
  logic        kbd_parity, kbd_strobe_n, bus_out_parity, bus_out_valid;
  logic        dev_addr_parity, dev_select, proc_busy, bus_in_parity;
  logic        bus_in_oe, key_pending, level3_req, process_check, irq;
  logic        in_process_lamp, cycle_steal_en, display_blank;
  logic        send, bad_par, done, clk_en;
  int          errors, checks;
  row_s        rows [0:4] = '{'{8'h00, 32'h100}, '{8'hff, 32'h1ff},
                             '{8'h5a, 32'h15a}, '{8'h81, 32'h181},
                             '{8'h07, 32'h007}};

  kbd_adapter dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .kbd_data(kbd_data),
    .kbd_parity(kbd_parity), .kbd_strobe_n(kbd_strobe_n),
    .bus_out(bus_out), .bus_out_parity(bus_out_parity),
    .bus_out_valid(bus_out_valid), .dev_addr(dev_addr),
    .dev_addr_parity(dev_addr_parity), .dev_select(dev_select),
    .proc_busy(proc_busy), .bus_in(bus_in), .bus_in_parity(bus_in_parity),
    .bus_in_oe(bus_in_oe), .key_pending(key_pending),
    .level3_req(level3_req), .process_check(process_check),
    .in_process_lamp(in_process_lamp), .cycle_steal_en(cycle_steal_en),
    .display_blank(display_blank), .irq(irq));

  kbd_model kbd (
    .hclk(hclk), .hresetn(hresetn), .send(send), .code(code),
    .bad_par(bad_par), .kbd_data(kbd_data), .kbd_parity(kbd_parity),
    .kbd_strobe_n(kbd_strobe_n), .done(done));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Pins are registered: let two edges land, then read the live pin
  task automatic chk_pin(input string n, input logic e, ref logic g);
    repeat (2) @(posedge hclk);
    #1;
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk_reg(n, e, x);
  endtask

  task automatic key(input logic [7:0] c, input logic bad);
    int n;
    @(posedge hclk);
    send    <= 1'b1;
    code    <= c;
    bad_par <= bad;
    @(posedge hclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic rst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, send, bad_par, proc_busy} = 6'h00;
    {bus_out_parity, bus_out_valid, dev_addr_parity, dev_select} = 4'h0;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize} = 5'h02;
    {code, bus_out, dev_addr} = 24'h0;
    errors = 0;
    clk_en = 1'b1;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rc("ctrl", OFF_CTRL, 32'h0);
    rc("status", OFF_STATUS, 32'h0);
    rc("evt_en", OFF_EVT_EN, 32'h0);
    rc("unmapped", 8'h1c, 32'h0);
    chk_pin("hresp", 1'b0, hresp);
    chk_pin("cycle_steal_en", 1'b1, cycle_steal_en);
    for (int i = 0; i < 5; i++) begin
      key(rows[i].code, 1'b0);
      rc("data", OFF_DATA, rows[i].data);
      rc("status", OFF_STATUS, 32'h1);
      chk_pin("level3_req", 1'b0, level3_req);
      chk_pin("bus_in_oe", 1'b0, bus_in_oe);
      wr(OFF_ACK, 32'h3);
      rc("status", OFF_STATUS, 32'h0);
    end
    wr(OFF_CTRL, 32'h1);
    wr(OFF_EVT_EN, 32'h1);
    wr(OFF_EVT_CLR, 32'hf);
    key(8'h11, 1'b0);
    chk_pin("level3_req", 1'b1, level3_req);
    chk_pin("irq", 1'b1, irq);
    key(8'h22, 1'b0);
    // Held repeat key: same code strobed again, delay not to scale
    key(8'h22, 1'b0);
    rc("data", OFF_DATA, 32'h122);
    rc("status", OFF_STATUS, 32'h3);
    @(posedge hclk);
    dev_select      <= 1'b1;
    dev_addr        <= KBD_DEV_ADDR;
    dev_addr_parity <= ^KBD_DEV_ADDR;
    chk_pin("bus_in_oe", 1'b1, bus_in_oe);
    chk_reg("bus_in", 32'h122, {23'h0, bus_in_parity, bus_in});
    @(posedge hclk);
    dev_addr        <= 8'h05;
    dev_addr_parity <= 1'b0;
    chk_pin("bus_in_oe", 1'b0, bus_in_oe);
    chk_pin("process_check", 1'b0, process_check);
    @(posedge hclk);
    dev_select <= 1'b0;
    wr(OFF_ACK, 32'h2);
    chk_pin("level3_req", 1'b1, level3_req);
    wr(OFF_EVT_EN, 32'h0);
    chk_pin("irq", 1'b0, irq);
    wr(OFF_EVT_EN, 32'h1);
    chk_pin("irq", 1'b1, irq);
    wr(OFF_EVT_CLR, 32'h1);
    chk_pin("irq", 1'b0, irq);
    wr(OFF_ACK, 32'h1);
    chk_pin("level3_req", 1'b0, level3_req);
    @(posedge hclk);
    clk_en    <= 1'b0;
    proc_busy <= 1'b1;
    // Frozen: lamp must ignore busy until enable returns
    chk_pin("in_process_lamp", 1'b0, in_process_lamp);
    @(posedge hclk);
    clk_en <= 1'b1;
    @(posedge hclk);
    proc_busy <= 1'b1;
    chk_pin("in_process_lamp", 1'b1, in_process_lamp);
    chk_pin("cycle_steal_en", 1'b0, cycle_steal_en);
    chk_pin("display_blank", 1'b1, display_blank);
    rc("status", OFF_STATUS, 32'h8);
    @(posedge hclk);
    proc_busy     <= 1'b0;
    bus_out       <= 8'h01;
    bus_out_valid <= 1'b1;
    chk_pin("process_check", 1'b0, process_check);
    @(posedge hclk);
    bus_out_parity <= 1'b1;
    chk_pin("process_check", 1'b1, process_check);
    @(posedge hclk);
    bus_out_valid <= 1'b0;
    key(8'h33, 1'b0);
    chk_pin("key_pending", 1'b0, key_pending);
    rc("evt_stat", OFF_EVT_STAT, 32'h2);
    rst();
    chk_pin("process_check", 1'b0, process_check);
    key(8'h44, 1'b1);
    chk_pin("process_check", 1'b1, process_check);
    rc("evt_stat", OFF_EVT_STAT, 32'h4);
    rst();
    @(posedge hclk);
    dev_select      <= 1'b1;
    dev_addr        <= KBD_DEV_ADDR;
    dev_addr_parity <= ~(^KBD_DEV_ADDR);
    chk_pin("process_check", 1'b1, process_check);
    chk_pin("bus_in_oe", 1'b0, bus_in_oe);
    @(posedge hclk);
    dev_select <= 1'b0;
    rst();
    chk_pin("process_check", 1'b0, process_check);
    print_verdict();
  end
endmodule
